// ==== rtl/sra_pkg.sv ====
package sra_pkg;

    // Frame layout
    localparam int FRAME_BITS = 24;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [3:0] HDR_LAST = 4'hE;
    localparam logic [3:0] BYTE_LAST = 4'h7;

    // Registers handled apart from the plain storage
    localparam logic [14:0] ADDR_PART_TYPE = 15'h0003;
    localparam logic [14:0] ADDR_PART_ID = 15'h0004;
    localparam logic [14:0] ADDR_MAKER_LO = 15'h000C;
    localparam logic [14:0] ADDR_MAKER_HI = 15'h000D;
    localparam logic [14:0] ADDR_SYSREF_CAPTURE_POSITION = 15'h002C;
    localparam logic [14:0] ADDR_CAL_STATE = 15'h006A;
    localparam logic [14:0] ADDR_LINK_STATUS = 15'h0208;

    // Field positions
    localparam int ASC_BIT = 5;
    localparam int ASC_MIRROR_BIT = 2;
    localparam int HOLD_BIT = 0;

    // Writable byte slots; 16-bit registers take two, low byte first
    localparam int NUM_RW = 38;
    localparam logic [5:0] NO_SLOT = 6'h26;
    localparam logic [5:0] SLOT_IF_PRIMARY = 6'h00;
    localparam logic [5:0] SLOT_USER_SERIAL = 6'h02;
    localparam logic [14:0] RW_ADDR [NUM_RW] = '{
        15'h0000, 15'h0002, 15'h0010, 15'h0029, 15'h002A, 15'h002B, 15'h0030, 15'h0031,
        15'h0032, 15'h0033, 15'h0038, 15'h003B, 15'h0048, 15'h0060, 15'h0061, 15'h0062,
        15'h0064, 15'h0068, 15'h006B, 15'h006C, 15'h006E, 15'h0070, 15'h0071, 15'h007A,
        15'h007B, 15'h007C, 15'h007E, 15'h007F, 15'h009D, 15'h0160, 15'h0200, 15'h0201,
        15'h0202, 15'h0203, 15'h0204, 15'h0205, 15'h0206, 15'h0207};
    localparam logic [7:0] RW_RESET [NUM_RW] = '{
        8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'hA0,
        8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
        8'h02, 8'h61, 8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02,
        8'h1F, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00};

    // Link timing
    localparam int CORE_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam logic [3:0] HALF_M1 = 4'(SCLK_HALF_CYC - 1);
    localparam logic [3:0] FULL_M1 = 4'(2 * SCLK_HALF_CYC - 1);
    localparam logic [3:0] SEL_HIGH_M1 = 4'(SCLK_HALF_CYC - 1);

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_HDR = 2'b01,
        DEV_DATA = 2'b11
    } sra_dev_state_t;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_RUN = 2'b01,
        HST_TAIL = 2'b11,
        HST_GAP = 2'b10
    } sra_hst_state_t;

    // Storage slot of a byte address, NO_SLOT when not writable
    function automatic logic [5:0] slotOf(input logic [14:0] addr);
        logic [5:0] s;
        s = NO_SLOT;
        for (int i = 0; i < NUM_RW; i++)
        begin
            if (RW_ADDR[i] == addr)
            begin
                s = 6'(i);
            end
        end
        return s;
    endfunction : slotOf

endpackage : sra_pkg

// ==== rtl/sra_if.sv ====
interface sra_if;
    logic sclk;
    logic serialSelectN;
    logic serialDataIn;
    logic serialDataOut;
    logic serialDataOutOe;
    logic serialDataOutLine;

    // Undriven output line floats high
    assign serialDataOutLine = serialDataOutOe ? serialDataOut : 1'b1;

    modport device (
        input sclk,
        input serialSelectN,
        input serialDataIn,
        output serialDataOut,
        output serialDataOutOe
    );

    modport host (
        output sclk,
        output serialSelectN,
        output serialDataIn,
        input serialDataOutLine
    );
endinterface : sra_if

// ==== rtl/sra_sync.sv ====
module sra_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // Two stages; the first is read by nothing but the second
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= asyncIn;
            sync_r <= meta_r;
        end
    end

    assign syncOut = sync_r;
endmodule : sra_sync

// ==== rtl/sra_device.sv ====
// Notes on behaviour
// - Host keeps select low for whole access.
// - Input bit sampled on serial clock rise.
// - Works at any slow serial clock.
// - Frame is 24 bits, MSB first.
// - Wide registers little-endian, low byte first.
// - Output floats in writes and header.
// - First bit one reads, zero writes.
// - Next fifteen bits carry the address.
// - Write stores last eight input bits.
// - Read ignores input, drives register byte.
// - Further bytes under select continue stream.
// - Address steps after each streamed byte.
// - Register zero bits 5,2 pick direction.
// - Address hold bit stops address stepping.
// - Host avoids access during calibration.
// - Host never writes unlisted addresses.
module sra_device #(
    parameter logic [7:0] PART_TYPE = 8'h5A,    // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h21,      // Arbitrary value
    parameter logic [15:0] MAKER_ID = 16'h1234  // Arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst,
    sra_if.device link,
    input wire logic [7:0] calState,
    input wire logic [7:0] sysrefPos,
    input wire logic [7:0] linkStatus,
    output logic wrStrobe,
    output logic [14:0] wrAddr,
    output logic [7:0] wrData,
    output logic [7:0] ifPrimary,
    output logic [7:0] userSerialConfig
);
    logic sclkS;
    logic serialSelectNS;
    logic serialDataInS;
    logic sclkPrev_r;
    sra_pkg::sra_dev_state_t state_r;
    logic [3:0] cnt_r;
    logic isRead_r;
    logic [14:0] addr_r;
    logic [7:0] rxSh_r;
    logic [7:0] txSh_r;
    logic loadTx_r;
    logic sdoOut_r;
    logic sdoOe_r;
    logic wrStrobe_r;
    logic [14:0] wrAddr_r;
    logic [7:0] wrData_r;
    logic [7:0] regFile_r [sra_pkg::NUM_RW];

    // All three pins come from the host's domain
    sra_sync #(
        .W(3)
    ) u_pinSync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn({link.sclk, link.serialSelectN, link.serialDataIn}),
        .syncOut({sclkS, serialSelectNS, serialDataInS})
    );

    // Edge detection on the synchronised serial clock
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sclkPrev_r <= 1'b0;
        end
        else
        begin
            sclkPrev_r <= sclkS;
        end
    end

    logic sclkRise;
    logic sclkFall;
    logic frameOn;
    assign sclkRise = sclkS & ~sclkPrev_r;
    assign sclkFall = ~sclkS & sclkPrev_r;
    assign frameOn = ~serialSelectNS;

    // Decode of the incoming bit stream, MSB first
    logic [14:0] hdrAddr;
    logic [7:0] rxByte;
    logic hdrDone;
    logic byteDone;
    assign rxByte = {rxSh_r[6:0], serialDataInS};
    // fifteen address bits follow the flag
    assign hdrAddr = {addr_r[13:0], serialDataInS};
    assign hdrDone = (state_r == sra_pkg::DEV_HDR) && (cnt_r == sra_pkg::HDR_LAST);
    assign byteDone = (state_r == sra_pkg::DEV_DATA) && (cnt_r == sra_pkg::BYTE_LAST);

    // Address stepping for streamed bytes
    logic ascend;
    logic addrHold;
    logic [14:0] stepAddr;
    // either mirror bit set means ascending, as after reset
    assign ascend = regFile_r[sra_pkg::SLOT_IF_PRIMARY][sra_pkg::ASC_BIT]
        | regFile_r[sra_pkg::SLOT_IF_PRIMARY][sra_pkg::ASC_MIRROR_BIT];
    assign addrHold = regFile_r[sra_pkg::SLOT_USER_SERIAL][sra_pkg::HOLD_BIT];
    // step up or down after each byte unless addrHold is set
    assign stepAddr = addrHold ? addr_r
        : (ascend ? 15'(addr_r + 15'h0001) : 15'(addr_r - 15'h0001));

    // Read selection; each byte of a wide register has its own address
    logic [5:0] rdSlot;
    logic [5:0] wrSlot;
    logic [7:0] rwByte;
    logic [7:0] rdByte;
    assign rdSlot = sra_pkg::slotOf(addr_r);
    assign wrSlot = sra_pkg::slotOf(addr_r);
    assign rwByte = (rdSlot == sra_pkg::NO_SLOT) ? 8'h00 : regFile_r[rdSlot];
    assign rdByte = (addr_r == sra_pkg::ADDR_PART_TYPE) ? PART_TYPE
        : (addr_r == sra_pkg::ADDR_PART_ID) ? PART_ID
        : (addr_r == sra_pkg::ADDR_MAKER_LO) ? MAKER_ID[7:0]
        : (addr_r == sra_pkg::ADDR_MAKER_HI) ? MAKER_ID[15:8]
        : (addr_r == sra_pkg::ADDR_SYSREF_CAPTURE_POSITION) ? sysrefPos
        : (addr_r == sra_pkg::ADDR_CAL_STATE) ? calState
        : (addr_r == sra_pkg::ADDR_LINK_STATUS) ? linkStatus
        : rwByte;

    // Frame sequencer; advances only on serial clock edges, so no rate floor
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r <= sra_pkg::DEV_IDLE;
            cnt_r <= 4'h0;
            isRead_r <= 1'b0;
            addr_r <= 15'h0000;
            rxSh_r <= 8'h00;
            loadTx_r <= 1'b0;
        end
        // select high returns to frame start
        else if (!frameOn)
        begin
            state_r <= sra_pkg::DEV_IDLE;
            cnt_r <= 4'h0;
            loadTx_r <= 1'b0;
        end
        else if (sclkRise)
        begin
            unique case (state_r)
                sra_pkg::DEV_IDLE:
                begin
                    isRead_r <= serialDataInS;
                    state_r <= sra_pkg::DEV_HDR;
                    cnt_r <= 4'h0;
                end
                sra_pkg::DEV_HDR:
                begin
                    addr_r <= hdrAddr;
                    loadTx_r <= hdrDone;
                    cnt_r <= hdrDone ? 4'h0 : 4'(cnt_r + 4'h1);
                    state_r <= hdrDone ? sra_pkg::DEV_DATA : sra_pkg::DEV_HDR;
                end
                sra_pkg::DEV_DATA:
                begin
                    rxSh_r <= rxByte;
                    cnt_r <= byteDone ? 4'h0 : 4'(cnt_r + 4'h1);
                    // stay in data phase for more bytes
                    if (byteDone)
                    begin
                        addr_r <= stepAddr;
                        loadTx_r <= 1'b1;
                    end
                end
                default:
                begin
                    state_r <= sra_pkg::DEV_IDLE;
                end
            endcase
        end
        else
        begin
            loadTx_r <= 1'b0;
        end
    end

    // Read output; byte loaded one cycle after the address settles
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            txSh_r <= 8'h00;
            sdoOut_r <= 1'b0;
            sdoOe_r <= 1'b0;
        end
        // floats outside the data phase of reads
        else if (!frameOn || state_r != sra_pkg::DEV_DATA || !isRead_r)
        begin
            sdoOe_r <= 1'b0;
            if (loadTx_r)
            begin
                txSh_r <= rdByte;
            end
        end
        else if (loadTx_r)
        begin
            txSh_r <= rdByte;
        end
        // bit driven on fall, host samples at the end of the high half
        else if (sclkFall)
        begin
            sdoOut_r <= txSh_r[7];
            txSh_r <= {txSh_r[6:0], 1'b0};
            sdoOe_r <= 1'b1;
        end
    end

    // Write commit, only after a whole data byte
    logic commit;
    assign commit = frameOn && sclkRise && byteDone && !isRead_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wrStrobe_r <= 1'b0;
            wrAddr_r <= 15'h0000;
            wrData_r <= 8'h00;
        end
        else
        begin
            // one-cycle strobe with address and byte
            wrStrobe_r <= commit;
            if (commit)
            begin
                wrAddr_r <= addr_r;
                wrData_r <= rxByte;
            end
        end
    end

    // Register storage; read-only and unmapped addresses drop writes
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < sra_pkg::NUM_RW; i++)
            begin
                regFile_r[i] <= sra_pkg::RW_RESET[i];
            end
        end
        else if (commit && wrSlot != sra_pkg::NO_SLOT)
        begin
            regFile_r[wrSlot] <= rxByte;
        end
    end

    assign link.serialDataOut = sdoOut_r;
    assign link.serialDataOutOe = sdoOe_r;
    assign wrStrobe = wrStrobe_r;
    assign wrAddr = wrAddr_r;
    assign wrData = wrData_r;
    assign ifPrimary = regFile_r[sra_pkg::SLOT_IF_PRIMARY];
    assign userSerialConfig = regFile_r[sra_pkg::SLOT_USER_SERIAL];
endmodule : sra_device

// ==== rtl/sra_host.sv ====
module sra_host (
    input wire logic core_clk,
    input wire logic rst,
    sra_if.host link,
    input wire logic cmdValid,
    input wire logic cmdRead,
    input wire logic [14:0] cmdAddr,
    input wire logic [1:0] cmdLen,
    input wire logic [31:0] cmdWrData,
    output logic cmdReady,
    output logic rspValid,
    output logic [31:0] rspData
);
    sra_pkg::sra_hst_state_t state_r;
    logic [3:0] divCnt_r;
    logic [5:0] bitCnt_r;
    logic [5:0] lastBit_r;
    logic [1:0] len_r;
    logic [47:0] txSh_r;
    logic [31:0] rxSh_r;
    logic sclk_r;
    logic selN_r;
    logic rspValid_r;
    logic [31:0] rspData_r;
    logic sdoS;

    // Device output comes from another domain
    sra_sync #(
        .W(1)
    ) u_sdoSync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn(link.serialDataOutLine),
        .syncOut(sdoS)
    );

    // Reorders received bytes so the first byte lands lowest
    function automatic logic [31:0] orderBytes(input logic [31:0] rx, input logic [1:0] len);
        logic [31:0] o;
        o = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            if (i <= int'(len))
            begin
                o[8*i +: 8] = rx[8*(int'(len) - i) +: 8];
            end
        end
        return o;
    endfunction : orderBytes

    logic [47:0] frameBits;
    logic endHigh;
    // Flag, address, then bytes low first; reads send zeros
    // flag leads frame
    assign frameBits = {cmdRead, cmdAddr,
        cmdRead ? 32'h0000_0000 : {cmdWrData[7:0], cmdWrData[15:8],
        cmdWrData[23:16], cmdWrData[31:24]}};
    assign endHigh = (divCnt_r == sra_pkg::FULL_M1);

    // Sequencer; the sampled output is read at the end of each high half,
    // late enough to cover the device's edge detect and our synchroniser
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_r <= sra_pkg::HST_IDLE;
            divCnt_r <= 4'h0;
            bitCnt_r <= 6'h00;
            lastBit_r <= 6'h00;
            len_r <= 2'h0;
            txSh_r <= 48'h0000_0000_0000;
            rxSh_r <= 32'h0000_0000;
            sclk_r <= 1'b0;
            selN_r <= 1'b1;
            rspValid_r <= 1'b0;
            rspData_r <= 32'h0000_0000;
        end
        else
        begin
            rspValid_r <= 1'b0;
            unique case (state_r)
                sra_pkg::HST_IDLE:
                begin
                    if (cmdValid)
                    begin
                        txSh_r <= frameBits;
                        len_r <= cmdLen;
                        lastBit_r <= 6'(sra_pkg::FRAME_BITS - 1 + 8 * int'(cmdLen));
                        bitCnt_r <= 6'h00;
                        divCnt_r <= 4'h0;
                        selN_r <= 1'b0;
                        state_r <= sra_pkg::HST_RUN;
                    end
                end
                sra_pkg::HST_RUN:
                begin
                    divCnt_r <= endHigh ? 4'h0 : 4'(divCnt_r + 4'h1);
                    if (divCnt_r == sra_pkg::HALF_M1)
                    begin
                        sclk_r <= 1'b1;
                    end
                    if (endHigh)
                    begin
                        sclk_r <= 1'b0;
                        rxSh_r <= {rxSh_r[30:0], sdoS};
                        txSh_r <= {txSh_r[46:0], 1'b0};
                        bitCnt_r <= 6'(bitCnt_r + 6'h01);
                        if (bitCnt_r == lastBit_r)
                        begin
                            state_r <= sra_pkg::HST_TAIL;
                        end
                    end
                end
                sra_pkg::HST_TAIL:
                begin
                    divCnt_r <= 4'(divCnt_r + 4'h1);
                    if (divCnt_r == sra_pkg::HALF_M1)
                    begin
                        divCnt_r <= 4'h0;
                        selN_r <= 1'b1;
                        state_r <= sra_pkg::HST_GAP;
                    end
                end
                sra_pkg::HST_GAP:
                begin
                    // Select stays high long enough for the device to see it
                    divCnt_r <= 4'(divCnt_r + 4'h1);
                    if (divCnt_r == sra_pkg::SEL_HIGH_M1)
                    begin
                        divCnt_r <= 4'h0;
                        rspValid_r <= 1'b1;
                        rspData_r <= orderBytes(rxSh_r, len_r);
                        state_r <= sra_pkg::HST_IDLE;
                    end
                end
            endcase
        end
    end

    assign cmdReady = (state_r == sra_pkg::HST_IDLE);
    assign rspValid = rspValid_r;
    assign rspData = rspData_r;
    assign link.sclk = sclk_r;
    assign link.serialSelectN = selN_r;
    assign link.serialDataIn = txSh_r[47];
endmodule : sra_host

// ==== tb/sra_sva.sv ====
module sra_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic serialSelectN,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutOe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic sclkQ_r;
    logic isRead_r;
    logic [6:0] bitCnt_r;
    logic [6:0] bitCnt_nxt;
    logic sclkRise;

    // Bits seen in the current frame; cleared whenever select is high
    assign sclkRise = sclk & ~sclkQ_r;
    assign bitCnt_nxt = serialSelectN ? 7'h00 : (bitCnt_r + {6'h00, sclkRise});

    // Edge history and frame direction, flag taken on the first rise
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sclkQ_r <= 1'b0;
            bitCnt_r <= 7'h00;
            isRead_r <= 1'b0;
        end
        else
        begin
            sclkQ_r <= sclk;
            bitCnt_r <= bitCnt_nxt;
            if (sclkRise && !serialSelectN && bitCnt_r == 7'h00)
                isRead_r <= serialDataIn;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_sclk_select_low: assert property (serialSelectN |-> !sclk)
        else $error("serial clock high while deselected");
    a_select_gap: assert property ($rose(serialSelectN) |-> serialSelectN [*4])
        else $error("select gap shorter than four cycles");
    a_bit_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase not four cycles");
    a_sdi_hold_high: assert property (sclk |-> $stable(serialDataIn))
        else $error("data in changed while serial clock high");
    a_frame_whole: assert property ($rose(serialSelectN) |->
        (bitCnt_r >= 7'h18) && (bitCnt_r[2:0] == 3'h0))
        else $error("frame not a whole number of bytes past 24 bits");
    a_oe_header_off: assert property (!serialSelectN && bitCnt_r < 7'h10 |-> !serialDataOutOe)
        else $error("output driven during header");
    a_oe_write_off: assert property (!serialSelectN && bitCnt_r != 7'h00 && !isRead_r
        |-> !serialDataOutOe)
        else $error("output driven during write frame");
    a_read_drives: assert property ($fell(sclk) && !serialSelectN && isRead_r
        && bitCnt_r > 7'h10 |-> serialDataOutOe)
        else $error("output not driven in read data phase");
    a_sdo_steady: assert property (serialDataOutOe && sclk && $past(sclk)
        |-> $stable(serialDataOut))
        else $error("read bit changed while serial clock high");
    a_oe_release: assert property (serialSelectN [*5] |-> !serialDataOutOe)
        else $error("output still driven after deselect");

    // Main traffic shapes
    c_read_single: cover property ($fell(sclk) && isRead_r && bitCnt_r == 7'h18);
    c_write_single: cover property ($rose(serialSelectN) && !isRead_r && bitCnt_r == 7'h18);
    c_stream_four: cover property ($rose(serialSelectN) && bitCnt_r == 7'h30);
endmodule : sra_sva

// ==== tb/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LIMIT = 40000;
    localparam logic [7:0] PART = 8'h77;     // Arbitrary value
    localparam logic [15:0] MAKER = 16'hBEEF; // Arbitrary value

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0;
    logic cmdRead = 1'b0;
    logic [14:0] cmdAddr = 15'h0000;
    logic [1:0] cmdLen = 2'h0;
    logic [31:0] cmdWrData = 32'h00000000;
    logic [7:0] calState = 8'h3C;
    logic [7:0] sysrefPos = 8'h5D;
    logic [7:0] linkStatus = 8'h6E;
    logic cmdReady, rspValid, wrStrobe, strobeB;
    logic [31:0] rspData, q;
    logic [14:0] wrAddr, lastAddr;
    logic [7:0] wrData, lastData, ifPrimary, userSerialConfig, rdb;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int nStrobe = 0;
    int nStrobeB = 0;

    sra_if link ();
    sra_if link2 ();

    sra_sva u_sra_sva (.core_clk(core_clk), .rst(rst), .sclk(link.sclk),
        .serialSelectN(link.serialSelectN), .serialDataIn(link.serialDataIn),
        .serialDataOut(link.serialDataOut), .serialDataOutOe(link.serialDataOutOe));
    sra_host u_sra_host (.core_clk(core_clk), .rst(rst), .link(link), .cmdValid(cmdValid),
        .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .cmdWrData(cmdWrData),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));
    sra_device #(.PART_TYPE(PART), .MAKER_ID(MAKER)) u_sra_device (.core_clk(core_clk),
        .rst(rst), .link(link), .calState(calState), .sysrefPos(sysrefPos),
        .linkStatus(linkStatus), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData),
        .ifPrimary(ifPrimary), .userSerialConfig(userSerialConfig));
    // Second device faces the bench directly, so faults can be injected
    sra_device #(.PART_TYPE(PART), .MAKER_ID(MAKER)) u_sra_device_b (.core_clk(core_clk),
        .rst(rst), .link(link2), .calState(calState), .sysrefPos(sysrefPos),
        .linkStatus(linkStatus), .wrStrobe(strobeB), .wrAddr(), .wrData(), .ifPrimary(),
        .userSerialConfig());

    always #50 core_clk = ~core_clk;

    // Strobe log and hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (wrStrobe === 1'b1)
        begin
            nStrobe++;
            lastAddr = wrAddr;
            lastData = wrData;
        end
        if (strobeB === 1'b1)
            nStrobeB++;
        if (cycles == LIMIT)
        begin
            n_errors++;
            $display("ERROR run time expected done seen hang");
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One host command; response time is fixed by the frame length
    task automatic hostCmd(input logic rd, input logic [14:0] a, input logic [1:0] len,
        input logic [31:0] wd);
        int n;
        n = 1;
        @(negedge core_clk);
        while (cmdReady !== 1'b1)
            @(negedge core_clk);
        cmdValid = 1'b1;
        cmdRead = rd;
        cmdAddr = a;
        cmdLen = len;
        cmdWrData = wd;
        @(negedge core_clk);
        cmdValid = 1'b0;
        while (rspValid !== 1'b1 && n < 2000)
        begin
            @(negedge core_clk);
            n++;
        end
        q = rspData;
        check("answer time", 32'(9 + (24 + 8 * int'(len)) * 8), 32'(n));
    endtask : hostCmd

    task automatic readChk(input logic [14:0] a, input logic [1:0] len, input logic [31:0] exp);
        hostCmd(1'b1, a, len, 32'h00000000);
        check($sformatf("reg %h", a), exp, q);
    endtask : readChk

    // Bench as serial master; bits past nb are never sent, so nb < 24 aborts
    task automatic bbFrame(input logic [23:0] f, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge core_clk);
        link2.serialSelectN = 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            link2.serialDataIn = f[23 - i];
            repeat (4) @(negedge core_clk);
            link2.sclk = 1'b1;
            repeat (4) @(negedge core_clk);
            rd = {rd[6:0], link2.serialDataOutLine};
            link2.sclk = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        link2.serialSelectN = 1'b1;
        link2.serialDataIn = ~link2.serialDataIn;
        repeat (8) @(negedge core_clk);
    endtask : bbFrame

    task final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // Main sequence
    initial
    begin
        link2.sclk = 1'b0;
        link2.serialSelectN = 1'b1;
        link2.serialDataIn = 1'b0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < sra_pkg::NUM_RW; i++)
            readChk(sra_pkg::RW_ADDR[i], 2'h0, {24'h000000, sra_pkg::RW_RESET[i]});
        readChk(15'h0030, 2'h1, 32'h0000A000);
        readChk(15'h000C, 2'h1, {16'h0000, MAKER});
        readChk(15'h006A, 2'h2, {8'h00, 8'h01, 8'h00, calState});
        readChk(15'h0208, 2'h0, {24'h000000, linkStatus});
        readChk(15'h002C, 2'h0, {24'h000000, sysrefPos});
        readChk(15'h0005, 2'h0, 32'h00000000);
        check("primary port", 32'h00000030, {24'h000000, ifPrimary});
        $display("test reset values done");
        hostCmd(1'b0, 15'h0029, 2'h0, 32'h000000A5);
        check("strobe addr", 32'h00000029, {17'h00000, lastAddr});
        check("strobe data", 32'h000000A5, {24'h000000, lastData});
        readChk(15'h0029, 2'h0, 32'h000000A5);
        hostCmd(1'b0, 15'h0003, 2'h0, 32'h000000FF);
        readChk(15'h0003, 2'h0, {24'h000000, PART});
        hostCmd(1'b0, 15'h0204, 2'h3, 32'h44332211);
        check("strobe count", 32'h00000006, 32'(nStrobe));
        readChk(15'h0204, 2'h3, 32'h44332211);
        $display("test write and stream done");
        hostCmd(1'b0, 15'h0000, 2'h0, 32'h00000000);
        check("primary port", 32'h00000000, {24'h000000, ifPrimary});
        hostCmd(1'b0, 15'h002A, 2'h1, 32'h0000B2B1);
        hostCmd(1'b0, 15'h0000, 2'h0, 32'h00000004);
        readChk(15'h0029, 2'h1, 32'h0000B1B2);
        hostCmd(1'b0, 15'h0000, 2'h0, 32'h00000030);
        hostCmd(1'b0, 15'h0010, 2'h0, 32'h00000001);
        check("user serial port", 32'h00000001, {24'h000000, userSerialConfig});
        hostCmd(1'b0, 15'h0060, 2'h1, 32'h00007766);
        check("strobe addr", 32'h00000060, {17'h00000, lastAddr});
        hostCmd(1'b0, 15'h0010, 2'h0, 32'h00000000);
        readChk(15'h0060, 2'h1, 32'h00000177);
        $display("test address direction done");
        bbFrame({1'b0, 15'h0029, 8'h5C}, 24, rdb);
        check("released line", 32'h000000FF, {24'h000000, rdb});
        bbFrame({1'b0, 15'h0029, 8'hFF}, 20, rdb);
        bbFrame({1'b1, 15'h0029, 8'hA3}, 24, rdb);
        check("aborted write", 32'h0000005C, {24'h000000, rdb});
        check("strobe count b", 32'h00000001, 32'(nStrobeB));
        $display("test abort done");
        final_report();
    end
endmodule : tb
